// >>> verilog/rsd_ops_cfg.svh
// Purpose: Constants for the rotate, subtract-with-borrow and decrement-skip datapath
// Assumes: 8-bit data memory bytes, 10 MHz core clock
// Notes:   Definitions only
`ifndef RSD_OPS_CFG_SVH
`define RSD_OPS_CFG_SVH
// ==========================================================
// Data and flag reset values
`define RSD_DATA_W        8
`define RSD_ACC_RST       8'h00
`define RSD_FLAG_RST      1'b0
// ==========================================================
// Flag vector bit positions
`define RSD_FLG_C         0
`define RSD_FLG_AC        1
`define RSD_FLG_Z         2
`define RSD_FLG_OV        3
`define RSD_FLG_SC        4
`define RSD_FLG_CZ        5
`define RSD_FLG_N         6
// ==========================================================
// Timing: cycles of a skipping decrement
`define RSD_SKIP_CYCLES   3
`endif

// >>> verilog/rsd_ops_pkg.sv
// Purpose: Types for the rotate, subtract-with-borrow and decrement-skip datapath
// Assumes: Included after rsd_ops_cfg.svh
// Notes:   Types only
`default_nettype none
package rsd_ops_pkg;
  typedef enum logic [2:0] {
    RSD_OP_NONE,
    RSD_OP_MEM_RRC,
    RSD_OP_ACC_RRC,
    RSD_OP_SBC_ACC,
    RSD_OP_SBC_MEM,
    RSD_OP_DEC_SKZ
  } rsd_op_e;
  typedef enum logic [1:0] {
    RSD_ST_IDLE,
    RSD_ST_WAIT,
    RSD_ST_DUMMY
  } rsd_state_e;
endpackage
`default_nettype wire

// >>> verilog/rsd_sub_unit.sv
// Purpose: Combinational subtract-with-borrow unit and its flags
// Assumes: Carry in is the true carry flag (borrow is its complement)
// Notes:   Pure logic, no state
`include "rsd_ops_cfg.svh"
`default_nettype none
module rsd_sub_unit #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] acc,
  input  wire logic [W-1:0] mem,
  input  wire logic         cin,
  input  wire logic         zin,
  output logic      [W-1:0] diff,
  output logic              cout,
  output logic              nib_c,
  output logic              zero,
  output logic              ovf,
  output logic              sgn_cmp,
  output logic              chn_zero
);
  logic [W:0] full;
  logic [4:0] lo;
  logic       neg;
  // Refuse widths that the nibble and sign taps cannot serve
  if (W < 8) begin : g_width_chk
    $error("rsd_sub_unit: W must be at least 8");
  end
  always_comb begin
    full     = {1'b0, acc} - {1'b0, mem} - {{W{1'b0}}, ~cin};
    lo       = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~cin};
    diff     = full[W-1:0];
    cout     = ~full[W];
    nib_c    = ~lo[4];
    zero     = (full[W-1:0] == '0);
    ovf      = (acc[W-1] ^ mem[W-1]) & (acc[W-1] ^ full[W-1]);
    neg      = full[W-1];
    sgn_cmp  = neg ^ ovf;
    chn_zero = zero & zin;
  end
endmodule
`default_nettype wire

// >>> verilog/rsd_ops_core.sv
// Purpose: Datapath for rotate through carry, subtract with borrow and decrement skip
// Assumes: Memory byte presented with op_start; result captured next edge
// Notes:
// Notes on behaviour
// - Memory rotate right through carry: old carry to bit 7, bit 0 to carry
// - Accumulator rotate: same rotation into accumulator, memory unchanged, carry from bit 0
// - Subtract to accumulator: acc minus mem minus inverted carry into accumulator
// - After subtract, carry 0 on negative result, 1 on zero or positive
// - Subtract to memory: same difference written back to memory byte
// - Subtracts update six flags; rotates change only carry
// - Decrement skip: memory byte minus one written back
// - Zero result skips next instruction with a dummy cycle, three cycles, no flags
`include "rsd_ops_cfg.svh"
`default_nettype none
module rsd_ops_core #(
  parameter int W = `RSD_DATA_W
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   op_start,
  input  wire rsd_ops_pkg::rsd_op_e   op_code,
  input  wire logic [W-1:0]           mem_rdata,
  output logic [W-1:0]                acc_ff,
  output logic [W-1:0]                mem_wdata_ff,
  output logic                        mem_we_ff,
  output logic                        carry_flag_ff,
  output logic                        nibble_carry_flag_ff,
  output logic                        zero_flag_ff,
  output logic                        signed_wrap_flag_ff,
  output logic                        signed_compare_flag_ff,
  output logic                        chained_zero_flag_ff,
  output logic                        skip_ff,
  output logic                        busy_ff,
  output logic                        done_ff
);
  // Refuse widths other than the byte that the flag logic is built for
  if (W != 8) begin : g_width_chk
    $error("rsd_ops_core: only 8-bit data supported");
  end
  // ==========================================================
  // Subtract unit
  logic [W-1:0] s_diff;
  logic         s_c;
  logic         s_ac;
  logic         s_z;
  logic         s_ov;
  logic         s_sc;
  logic         s_cz;
  rsd_sub_unit #(.W(W)) u_sub (
    .acc      (acc_ff),
    .mem      (mem_rdata),
    .cin      (carry_flag_ff),
    .zin      (zero_flag_ff),
    .diff     (s_diff),
    .cout     (s_c),
    .nib_c    (s_ac),
    .zero     (s_z),
    .ovf      (s_ov),
    .sgn_cmp  (s_sc),
    .chn_zero (s_cz)
  );
  // ==========================================================
  // Next-state logic
  rsd_ops_pkg::rsd_state_e state_ff;
  rsd_ops_pkg::rsd_state_e nxt_state;
  logic [W-1:0] nxt_acc;
  logic [W-1:0] nxt_wdata;
  logic         nxt_we;
  logic         nxt_c;
  logic         nxt_ac;
  logic         nxt_z;
  logic         nxt_ov;
  logic         nxt_sc;
  logic         nxt_cz;
  logic         nxt_skip;
  logic         nxt_busy;
  logic         nxt_done;
  logic [W-1:0] rrc;
  logic [W-1:0] dec;
  always_comb begin
    rrc       = {carry_flag_ff, mem_rdata[W-1:1]};
    dec       = mem_rdata - {{(W-1){1'b0}}, 1'b1};
    nxt_state = state_ff;
    nxt_acc   = acc_ff;
    nxt_wdata = mem_wdata_ff;
    nxt_we    = 1'b0;
    nxt_c     = carry_flag_ff;
    nxt_ac    = nibble_carry_flag_ff;
    nxt_z     = zero_flag_ff;
    nxt_ov    = signed_wrap_flag_ff;
    nxt_sc    = signed_compare_flag_ff;
    nxt_cz    = chained_zero_flag_ff;
    nxt_skip  = 1'b0;
    nxt_busy  = 1'b0;
    nxt_done  = 1'b0;
    unique case (state_ff)
      rsd_ops_pkg::RSD_ST_IDLE: begin
        if (op_start) begin
          nxt_done = 1'b1;
          unique case (op_code)
            rsd_ops_pkg::RSD_OP_MEM_RRC: begin
              nxt_wdata = rrc;
              nxt_we    = 1'b1;
              nxt_c     = mem_rdata[0];
            end
            rsd_ops_pkg::RSD_OP_ACC_RRC: begin
              nxt_acc = rrc;
              nxt_c   = mem_rdata[0];
            end
            rsd_ops_pkg::RSD_OP_SBC_ACC, rsd_ops_pkg::RSD_OP_SBC_MEM: begin
              if (op_code == rsd_ops_pkg::RSD_OP_SBC_ACC) begin
                nxt_acc = s_diff;
              end else begin
                nxt_wdata = s_diff;
                nxt_we    = 1'b1;
              end
              nxt_c  = s_c;
              nxt_ac = s_ac;
              nxt_z  = s_z;
              nxt_ov = s_ov;
              nxt_sc = s_sc;
              nxt_cz = s_cz;
            end
            rsd_ops_pkg::RSD_OP_DEC_SKZ: begin
              nxt_wdata = dec;
              nxt_we    = 1'b1;
              if (dec == '0) begin
                nxt_done  = 1'b0;
                nxt_busy  = 1'b1;
                nxt_state = rsd_ops_pkg::RSD_ST_WAIT;
              end
            end
            default: nxt_done = 1'b1;
          endcase
        end
      end
      rsd_ops_pkg::RSD_ST_WAIT: begin
        nxt_busy  = 1'b1;
        nxt_state = rsd_ops_pkg::RSD_ST_DUMMY;
      end
      rsd_ops_pkg::RSD_ST_DUMMY: begin
        nxt_skip  = 1'b1;
        nxt_done  = 1'b1;
        nxt_state = rsd_ops_pkg::RSD_ST_IDLE;
      end
    endcase
  end
  // ==========================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_ff               <= rsd_ops_pkg::RSD_ST_IDLE;
      acc_ff                 <= `RSD_ACC_RST;
      mem_wdata_ff           <= `RSD_ACC_RST;
      mem_we_ff              <= 1'b0;
      carry_flag_ff          <= `RSD_FLAG_RST;
      nibble_carry_flag_ff   <= `RSD_FLAG_RST;
      zero_flag_ff           <= `RSD_FLAG_RST;
      signed_wrap_flag_ff    <= `RSD_FLAG_RST;
      signed_compare_flag_ff <= `RSD_FLAG_RST;
      chained_zero_flag_ff   <= `RSD_FLAG_RST;
      skip_ff                <= 1'b0;
      busy_ff                <= 1'b0;
      done_ff                <= 1'b0;
    end else begin
      state_ff               <= nxt_state;
      acc_ff                 <= nxt_acc;
      mem_wdata_ff           <= nxt_wdata;
      mem_we_ff              <= nxt_we;
      carry_flag_ff          <= nxt_c;
      nibble_carry_flag_ff   <= nxt_ac;
      zero_flag_ff           <= nxt_z;
      signed_wrap_flag_ff    <= nxt_ov;
      signed_compare_flag_ff <= nxt_sc;
      chained_zero_flag_ff   <= nxt_cz;
      skip_ff                <= nxt_skip;
      busy_ff                <= nxt_busy;
      done_ff                <= nxt_done;
    end
  end
  // ==========================================================
  // Checks
  logic idle_start;
  assign idle_start = op_start && (state_ff == rsd_ops_pkg::RSD_ST_IDLE);
  sequence s_dec_zero;
    idle_start && op_code == rsd_ops_pkg::RSD_OP_DEC_SKZ && mem_rdata == 8'h01;
  endsequence
  sequence s_skip_tail;
    busy_ff ##1 busy_ff ##1 skip_ff && done_ff;
  endsequence
  AST_MEM_RRC: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && op_code == rsd_ops_pkg::RSD_OP_MEM_RRC |=>
      mem_we_ff && mem_wdata_ff == {$past(carry_flag_ff), $past(mem_rdata[7:1])}
      && carry_flag_ff == $past(mem_rdata[0]))
    else $error("memory rotate result wrong");
  AST_ACC_RRC: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && op_code == rsd_ops_pkg::RSD_OP_ACC_RRC |=>
      !mem_we_ff && acc_ff == {$past(carry_flag_ff), $past(mem_rdata[7:1])})
    else $error("accumulator rotate result wrong");
  AST_SBC_ACC: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && op_code == rsd_ops_pkg::RSD_OP_SBC_ACC |=>
      acc_ff == 8'($past(acc_ff) - $past(mem_rdata) - {7'h00, ~$past(carry_flag_ff)}))
    else $error("subtract to accumulator wrong");
  AST_SBC_C: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && (op_code == rsd_ops_pkg::RSD_OP_SBC_ACC
      || op_code == rsd_ops_pkg::RSD_OP_SBC_MEM)
      |=> carry_flag_ff == ({1'b0, $past(acc_ff)} >= 9'({1'b0, $past(mem_rdata)}
          + {8'h00, ~$past(carry_flag_ff)})))
    else $error("subtract carry wrong");
  AST_SBC_MEM: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && op_code == rsd_ops_pkg::RSD_OP_SBC_MEM |=> mem_we_ff && $stable(acc_ff)
      && mem_wdata_ff == 8'($past(acc_ff) - $past(mem_rdata) - {7'h00, ~$past(carry_flag_ff)}))
    else $error("subtract to memory wrong");
  AST_RRC_FLAGS: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && (op_code == rsd_ops_pkg::RSD_OP_MEM_RRC
      || op_code == rsd_ops_pkg::RSD_OP_ACC_RRC)
      |=> $stable(zero_flag_ff) && $stable(signed_wrap_flag_ff) && $stable(nibble_carry_flag_ff)
      && $stable(signed_compare_flag_ff) && $stable(chained_zero_flag_ff))
    else $error("rotate touched a flag other than carry");
  AST_DEC: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && op_code == rsd_ops_pkg::RSD_OP_DEC_SKZ |=>
      mem_we_ff && mem_wdata_ff == 8'($past(mem_rdata) - 8'h01))
    else $error("decrement write-back wrong");
  AST_DEC_FLAGS: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && op_code == rsd_ops_pkg::RSD_OP_DEC_SKZ |=> $stable(carry_flag_ff)
      && $stable(zero_flag_ff) && $stable(nibble_carry_flag_ff) && $stable(signed_wrap_flag_ff)
      && $stable(signed_compare_flag_ff) && $stable(chained_zero_flag_ff))
    else $error("decrement changed a flag");
  AST_SKIP: assert property (@(posedge mclk) disable iff (!resetn)
    s_dec_zero |=> s_skip_tail)
    else $error("zero decrement did not take three cycles with skip");
  AST_ZERO: assert property (@(posedge mclk) disable iff (!resetn)
    idle_start && op_code == rsd_ops_pkg::RSD_OP_SBC_ACC |=> zero_flag_ff == (acc_ff == 8'h00))
    else $error("zero flag wrong after subtract");
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the rotate, subtract and decrement-skip datapath
// Assumes: Package and design compiled before this file
// Notes:   Expected values come from a small model of the accumulator and flags
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 mclk;
  logic                 resetn;
  logic                 op_start;
  rsd_ops_pkg::rsd_op_e op_code;
  logic [7:0]           mem_rdata;
  logic [7:0]           acc_ff;
  logic [7:0]           mem_wdata_ff;
  logic                 mem_we_ff;
  wire  [5:0]           flg;
  logic                 skip_ff;
  logic                 busy_ff;
  logic                 done_ff;
  logic [7:0]           e_acc;
  logic [5:0]           ef;
  logic                 g_we;
  logic                 g_busy;
  logic                 g_skip;
  logic [7:0]           g_wd;
  int                   g_n;
  int                   fails;
  int                   tests_run;

  rsd_ops_core i_rsd_ops_core (
    .mclk                   (mclk),
    .resetn                 (resetn),
    .op_start               (op_start),
    .op_code                (op_code),
    .mem_rdata              (mem_rdata),
    .acc_ff                 (acc_ff),
    .mem_wdata_ff           (mem_wdata_ff),
    .mem_we_ff              (mem_we_ff),
    .carry_flag_ff          (flg[0]),
    .nibble_carry_flag_ff   (flg[1]),
    .zero_flag_ff           (flg[2]),
    .signed_wrap_flag_ff    (flg[3]),
    .signed_compare_flag_ff (flg[4]),
    .chained_zero_flag_ff   (flg[5]),
    .skip_ff                (skip_ff),
    .busy_ff                (busy_ff),
    .done_ff                (done_ff)
  );

  // ==========================================================
  // Shared tasks
  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic issue(input rsd_ops_pkg::rsd_op_e op, input logic [7:0] m);
    @(posedge mclk);
    #1;
    op_start = 1'h1;
    op_code = op;
    mem_rdata = m;
    @(posedge mclk);
    #1;
    op_start = 1'h0;
    mem_rdata = ~m;
    g_we = mem_we_ff;
    g_wd = mem_wdata_ff;
    g_busy = busy_ff;
    g_n = 0;
    while (done_ff !== 1'h1 && g_n < 6) begin
      @(posedge mclk);
      #1;
      g_n++;
    end
    if (g_n >= 6) begin
      fails++;
      $display("MISMATCH %0t no completion", $time);
      results();
    end
    g_skip = skip_ff;
  endtask

  task automatic chk_state(input logic we, input logic [7:0] wd);
    chk(acc_ff, e_acc, "acc");
    chk({2'h0, flg}, {2'h0, ef}, "flags");
    chk({7'h00, g_we}, {7'h00, we}, "write strobe");
    if (we) begin
      chk(g_wd, wd, "write data");
    end
  endtask

  task automatic do_rot(input logic to_mem, input logic [7:0] m);
    logic [7:0] r;
    r = {ef[0], m[7:1]};
    ef[0] = m[0];
    issue(to_mem ? rsd_ops_pkg::RSD_OP_MEM_RRC : rsd_ops_pkg::RSD_OP_ACC_RRC, m);
    if (!to_mem) begin
      e_acc = r;
    end
    chk_state(to_mem, r);
  endtask

  task automatic do_sbc(input logic to_mem, input logic [7:0] m);
    logic [8:0] d;
    logic [4:0] h;
    logic       ov;
    logic       z;
    d = {1'h0, e_acc} - {1'h0, m} - {8'h00, ~ef[0]};
    h = {1'h0, e_acc[3:0]} - {1'h0, m[3:0]} - {4'h0, ~ef[0]};
    ov = (e_acc[7] != m[7]) && (d[7] != e_acc[7]);
    z = (d[7:0] == 8'h00);
    ef = {z & ef[2], d[7] ^ ov, ov, z, ~h[4], ~d[8]};
    issue(to_mem ? rsd_ops_pkg::RSD_OP_SBC_MEM : rsd_ops_pkg::RSD_OP_SBC_ACC, m);
    if (!to_mem) begin
      e_acc = d[7:0];
    end
    chk_state(to_mem, d[7:0]);
  endtask

  task automatic do_dec(input logic [7:0] m);
    logic [7:0] r;
    logic       z;
    r = m - 8'h01;
    z = (r == 8'h00);
    issue(rsd_ops_pkg::RSD_OP_DEC_SKZ, m);
    chk_state(1'h1, r);
    chk(8'(g_n), z ? 8'h02 : 8'h00, "extra cycles");
    chk({6'h00, g_busy, g_skip}, {6'h00, z, z}, "busy and skip");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_rotate();
    do_rot(1'h0, 8'hA5);
    do_rot(1'h0, 8'h3C);
    do_rot(1'h1, 8'h81);
    do_rot(1'h1, 8'h02);
  endtask

  task automatic t_sub_acc();
    do_rot(1'h0, 8'h01);
    do_rot(1'h0, 8'h01);
    do_sbc(1'h0, 8'h01);
    do_sbc(1'h0, 8'h7F);
    do_sbc(1'h0, 8'h00);
    do_sbc(1'h0, 8'h01);
    do_sbc(1'h0, 8'h00);
  endtask

  task automatic t_sub_mem();
    do_sbc(1'h1, 8'h10);
    do_sbc(1'h1, 8'hFE);
  endtask

  task automatic t_dec();
    do_dec(8'h05);
    do_dec(8'h01);
    do_dec(8'h00);
    do_dec(8'h01);
  endtask

  task automatic t_misc();
    issue(rsd_ops_pkg::RSD_OP_NONE, 8'h5A);
    chk_state(1'h0, 8'h00);
    resetn = 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'h1;
    e_acc = 8'h00;
    ef = 6'h00;
    g_we = mem_we_ff;
    chk_state(1'h0, 8'h00);
    chk({5'h00, busy_ff, skip_ff, done_ff}, 8'h00, "control after reset");
    do_rot(1'h0, 8'hC3);
  endtask

  // ==========================================================
  // Clock and main sequence
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    resetn = 1'h0;
    op_start = 1'h0;
    op_code = rsd_ops_pkg::RSD_OP_NONE;
    mem_rdata = 8'h00;
    fails = 0;
    tests_run = 0;
    e_acc = 8'h00;
    ef = 6'h00;
    repeat (16) @(posedge mclk);
    #1;
    resetn = 1'h1;
    g_we = mem_we_ff;
    chk_state(1'h0, 8'h00);
    t_rotate();
    t_sub_acc();
    t_sub_mem();
    t_dec();
    t_misc();
    results();
  end
endmodule
`default_nettype wire
